// *** design/sscm_pkg.sv ***
// Package for the stream special channel multiplexer
package sscm_pkg;
    // =====================================================
    // Channel codes
    localparam logic [7:0] CH_EXT_FLEX    = 8'hC1;
    localparam logic [7:0] CH_MUX_CTRL    = 8'hC2;
    localparam logic [7:0] CH_TIMER_BASE  = 8'hC8;
    localparam logic [7:0] CH_TIMER_LAST  = 8'hCB;
    localparam logic [7:0] CH_COUNT_BASE  = 8'hD2;
    localparam logic [7:0] CH_COUNT_LAST  = 8'hD3;
    localparam logic [7:0] CH_CAPTURE     = 8'hE0;
    localparam logic [7:0] CH_TIMER_RBASE = 8'hE6;
    localparam logic [7:0] CH_TIMER_RLAST = 8'hE9;
    localparam logic [7:0] CH_COUNT_RBASE = 8'hF0;
    localparam logic [7:0] CH_COUNT_RLAST = 8'hF1;
    localparam logic [7:0] CH_ANALOG_LAST = 8'h0F;

    // =====================================================
    // Sizes and reset values
    localparam int         NUM_TIMERS     = 4;
    localparam int         NUM_COUNTERS   = 2;
    localparam int         NUM_SOURCES    = 6;
    localparam logic [15:0] LATCH_RESET   = 16'h0000;
    localparam logic [15:0] WORD_RESET    = 16'h0000;

    // =====================================================
    // Types
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HOLD = 3'b010,
        ST_DONE = 3'b100
    } sscm_state_e;

    typedef struct packed {
        logic [7:0] flexible_io_port;
        logic [7:0] extended_io_port;
        logic [7:0] control_io_port;
        logic [7:0] multiplexer_io_port;
    } sscm_ports_s;

    typedef struct packed {
        logic        valid;
        logic        stream;
        logic [7:0]  code;
    } sscm_req_s;

    typedef struct packed {
        logic        valid;
        logic        is_special;
        logic        error;
        logic [31:0] data;
    } sscm_resp_s;

    typedef struct packed {
        sscm_state_e state;
        sscm_ports_s ports_meta;
        sscm_ports_s ports_sync;
        logic [15:0] timer_counter_high_half_latch;
        sscm_resp_s  resp;
        logic        analog_start;
        logic [NUM_SOURCES-1:0] clear_src;
        logic [7:0]  held_code;
        logic        held_stream;
    } sscm_state_s;
endpackage

// *** design/sscm_stream_special_channel_mux.sv ***
// Stream special channel multiplexer: digital port snapshots and timer/counter sampling
`timescale 1ns/1ps
`default_nettype none

module sscm_stream_special_channel_mux (
    // Clock and reset
    input  wire logic                 CLOCK,
    input  wire logic                 RESET_N,
    // Sample slot request from the sequencer
    input  wire sscm_pkg::sscm_req_s  REQ,
    // Slot end from the analog slot timer
    input  wire logic                 SLOT_DONE,
    // Analog conversion result
    input  wire logic [15:0]          ANALOG_DATA,
    // Digital port pins
    input  wire sscm_pkg::sscm_ports_s PORT_PINS,
    // Timer and counter values, same clock
    input  wire logic [191:0]         SOURCE_VALUES,
    // Results
    output var  sscm_pkg::sscm_resp_s RESP,
    output var  logic                 ANALOG_START,
    output var  logic [5:0]           SOURCE_CLEAR
);

    // =====================================================
    // Decoding helpers
    function automatic logic in_range(input logic [7:0] c, input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (c >= lo) && (c <= hi);
    endfunction

    // Source index 0..5 for a timer/counter code, 7 when none
    function automatic logic [2:0] src_index(input logic [7:0] c);
        logic [7:0] d;
        d = 8'h00;
        src_index = 3'h7;
        if (in_range(c, sscm_pkg::CH_TIMER_BASE, sscm_pkg::CH_TIMER_LAST)) begin
            d = c - sscm_pkg::CH_TIMER_BASE;
            src_index = d[2:0];
        end else if (in_range(c, sscm_pkg::CH_TIMER_RBASE, sscm_pkg::CH_TIMER_RLAST)) begin
            d = c - sscm_pkg::CH_TIMER_RBASE;
            src_index = d[2:0];
        end else if (in_range(c, sscm_pkg::CH_COUNT_BASE, sscm_pkg::CH_COUNT_LAST)) begin
            d = c - sscm_pkg::CH_COUNT_BASE + 8'h04;
            src_index = d[2:0];
        end else if (in_range(c, sscm_pkg::CH_COUNT_RBASE, sscm_pkg::CH_COUNT_RLAST)) begin
            d = c - sscm_pkg::CH_COUNT_RBASE + 8'h04;
            src_index = d[2:0];
        end
    endfunction

    function automatic logic is_reset_code(input logic [7:0] c);
        is_reset_code = in_range(c, sscm_pkg::CH_TIMER_RBASE, sscm_pkg::CH_TIMER_RLAST)
                     || in_range(c, sscm_pkg::CH_COUNT_RBASE, sscm_pkg::CH_COUNT_RLAST);
    endfunction

    // =====================================================
    // State
    sscm_pkg::sscm_state_s st_reg;
    sscm_pkg::sscm_state_s st_next;

    logic [2:0]  cur_src;
    logic [31:0] cur_val;
    logic [7:0]  held_code_reg;
    logic        held_stream_reg;

    // Views of the request held for the whole slot
    always_comb begin
        held_code_reg = st_reg.held_code;
        held_stream_reg = st_reg.held_stream;
        cur_src = src_index(held_code_reg);
        cur_val = (cur_src < 3'h6) ? SOURCE_VALUES[32*cur_src +: 32] : 32'h0000_0000;
    end

    always_comb begin
        st_next = st_reg;
        st_next.ports_meta = PORT_PINS;
        st_next.ports_sync = st_reg.ports_meta;
        st_next.resp.valid = 1'b0;
        st_next.analog_start = 1'b0;
        st_next.clear_src = '0;
        case (st_reg.state)
            sscm_pkg::ST_IDLE: begin
                if (REQ.valid) begin
                    st_next.state = sscm_pkg::ST_HOLD;
                    // Code is kept so a late change on the request cannot alter the slot
                    st_next.held_code = REQ.code;
                    st_next.held_stream = REQ.stream;
                    // Every code, special or not, opens a normal slot
                    st_next.analog_start = 1'b1;
                end
            end
            sscm_pkg::ST_HOLD: begin
                if (SLOT_DONE) begin
                    st_next.state = sscm_pkg::ST_DONE;
                    st_next.resp.valid = 1'b1;
                    st_next.resp.is_special = 1'b1;
                    st_next.resp.error = 1'b0;
                    st_next.resp.data = 32'h0000_0000;
                    if (held_code_reg == sscm_pkg::CH_EXT_FLEX) begin
                        // Read only; bits of non-input lines pass through as is
                        st_next.resp.data[15:0] = {st_reg.ports_sync.extended_io_port,
                                                   st_reg.ports_sync.flexible_io_port};
                    end else if (held_code_reg == sscm_pkg::CH_MUX_CTRL) begin
                        st_next.resp.data[15:0] = {st_reg.ports_sync.multiplexer_io_port,
                                                   st_reg.ports_sync.control_io_port};
                    end else if (cur_src < 3'h6) begin
                        if (held_stream_reg) begin
                            st_next.resp.data[15:0] = cur_val[15:0];
                            st_next.timer_counter_high_half_latch = cur_val[31:16];
                        end else begin
                            st_next.resp.data = cur_val;
                        end
                        if (is_reset_code(held_code_reg)) begin
                            st_next.clear_src[cur_src] = 1'b1;
                        end
                    end else if (held_code_reg == sscm_pkg::CH_CAPTURE && held_stream_reg) begin
                        st_next.resp.data[15:0] = st_reg.timer_counter_high_half_latch;
                    end else if (held_code_reg <= sscm_pkg::CH_ANALOG_LAST) begin
                        // Analog sample leaves the latch alone
                        st_next.resp.is_special = 1'b0;
                        st_next.resp.data[15:0] = ANALOG_DATA;
                    end else begin
                        // Includes system timer codes: not streamable
                        st_next.resp.error = 1'b1;
                    end
                end
            end
            sscm_pkg::ST_DONE: begin
                st_next.state = sscm_pkg::ST_IDLE;
            end
            default: begin
                st_next.state = sscm_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_reg <= '{state: sscm_pkg::ST_IDLE, ports_meta: '0, ports_sync: '0,
                        timer_counter_high_half_latch: sscm_pkg::LATCH_RESET,
                        resp: '0, analog_start: 1'b0, clear_src: '0,
                        held_code: 8'h00, held_stream: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    always_comb begin
        RESP = st_reg.resp;
        ANALOG_START = st_reg.analog_start;
        SOURCE_CLEAR = st_reg.clear_src;
    end

    // =====================================================
    // Checks
    a_low_half_return: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (st_reg.state == sscm_pkg::ST_HOLD && SLOT_DONE && held_stream_reg && cur_src < 3'h6)
        |=> (RESP.data[15:0] == $past(cur_val[15:0])
             && st_reg.timer_counter_high_half_latch == $past(cur_val[31:16])))
        else $error("timer low half or latch wrong");
    a_latch_holds: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        !(st_reg.state == sscm_pkg::ST_HOLD && SLOT_DONE && held_stream_reg && cur_src < 3'h6)
        |=> $stable(st_reg.timer_counter_high_half_latch))
        else $error("capture latch changed without source sample");
    a_capture_read: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (st_reg.state == sscm_pkg::ST_HOLD && SLOT_DONE && held_stream_reg
         && held_code_reg == sscm_pkg::CH_CAPTURE)
        |=> RESP.valid && RESP.data[15:0] == st_reg.timer_counter_high_half_latch)
        else $error("capture read wrong");
    a_clear_only_reset: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (SOURCE_CLEAR != 6'h00) |-> RESP.valid && $past(is_reset_code(held_code_reg)))
        else $error("clear without reset code");
    a_full_word: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (st_reg.state == sscm_pkg::ST_HOLD && SLOT_DONE && !held_stream_reg && cur_src < 3'h6)
        |=> RESP.data == $past(cur_val) && $stable(st_reg.timer_counter_high_half_latch))
        else $error("command read not full width");
    a_port_word: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (st_reg.state == sscm_pkg::ST_HOLD && SLOT_DONE && held_code_reg == sscm_pkg::CH_EXT_FLEX)
        |=> RESP.data[7:0] == $past(st_reg.ports_sync.flexible_io_port)
            && RESP.data[15:8] == $past(st_reg.ports_sync.extended_io_port))
        else $error("port word 193 wrong");
    a_ctrl_word: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (st_reg.state == sscm_pkg::ST_HOLD && SLOT_DONE && held_code_reg == sscm_pkg::CH_MUX_CTRL)
        |=> RESP.data[7:0] == $past(st_reg.ports_sync.control_io_port)
            && RESP.data[15:8] == $past(st_reg.ports_sync.multiplexer_io_port))
        else $error("port word 194 wrong");
    a_one_slot: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (st_reg.state == sscm_pkg::ST_IDLE && REQ.valid) |=> ANALOG_START ##1 !ANALOG_START)
        else $error("slot not opened once");
    a_no_error_port: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (RESP.valid && $past(held_code_reg) == sscm_pkg::CH_EXT_FLEX) |-> !RESP.error)
        else $error("port read flagged error");
    a_systimer_refused: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (st_reg.state == sscm_pkg::ST_HOLD && SLOT_DONE && held_code_reg > sscm_pkg::CH_COUNT_RLAST)
        |=> RESP.error)
        else $error("unsupported code not refused");
    a_capture_command: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (st_reg.state == sscm_pkg::ST_HOLD && SLOT_DONE && !held_stream_reg
         && held_code_reg == sscm_pkg::CH_CAPTURE)
        |=> RESP.valid && RESP.error && $stable(st_reg.timer_counter_high_half_latch))
        else $error("command capture read not refused");
    a_analog_word: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (st_reg.state == sscm_pkg::ST_HOLD && SLOT_DONE
         && held_code_reg <= sscm_pkg::CH_ANALOG_LAST)
        |=> !RESP.is_special && RESP.data[15:0] == $past(ANALOG_DATA)
            && $stable(st_reg.timer_counter_high_half_latch))
        else $error("analog sample wrong or latch moved");

endmodule

`default_nettype wire

// *** test/sscm_slot_model.sv ***
// Slot timer and analog converter model facing the multiplexer
`timescale 1ns/1ps
`default_nettype none
module sscm_slot_model (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // Slot control and result
    input  wire logic        analog_start,
    input  wire logic [3:0]  slot_len,
    input  wire logic [15:0] sample_value,
    output logic             slot_done,
    output logic [15:0]      analog_data
);
    logic [3:0] count_reg;
    logic       busy_reg;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_reg   <= 4'h0;
            busy_reg    <= 1'b0;
            slot_done   <= 1'b0;
            analog_data <= 16'h5A5A;
        end else begin
            slot_done   <= 1'b0;
            // Result is only good in the slot-end cycle
            analog_data <= ~analog_data;
            if (analog_start) begin
                busy_reg  <= 1'b1;
                count_reg <= slot_len;
            end else if (busy_reg && count_reg == 4'h0) begin
                busy_reg    <= 1'b0;
                slot_done   <= 1'b1;
                analog_data <= sample_value;
            end else if (busy_reg) begin
                count_reg <= count_reg - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// *** test/sscm_stream_special_channel_mux_tb_top.sv ***
// Testbench for the stream special channel multiplexer
`timescale 1ns/1ps
`default_nettype none
module sscm_stream_special_channel_mux_tb_top;
    logic                 clock, reset_n, slot_done, analog_start;
    logic [15:0]          adata;
    logic [3:0]           slot_len;
    logic [191:0]         src;
    logic [5:0]           clr;
    sscm_pkg::sscm_req_s  req;
    sscm_pkg::sscm_ports_s pins;
    sscm_pkg::sscm_resp_s resp;
    int                   fails, check_count;

    sscm_stream_special_channel_mux u_dut (.CLOCK(clock), .RESET_N(reset_n), .REQ(req),
        .SLOT_DONE(slot_done), .ANALOG_DATA(adata), .PORT_PINS(pins),
        .SOURCE_VALUES(src), .RESP(resp), .ANALOG_START(analog_start), .SOURCE_CLEAR(clr));
    sscm_slot_model u_slot (.clock(clock), .reset_n(reset_n), .analog_start(analog_start),
        .slot_len(slot_len), .sample_value(16'h3C3C), .slot_done(slot_done),
        .analog_data(adata));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("Counts: checks=%0d mismatches=%0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // One scan entry; error and clear are always judged, data width by mode
    task automatic entry(input logic strm, input logic [7:0] code, input logic [31:0] exp,
                         input logic err, input logic [5:0] exp_clr);
        int starts;
        int n;
        starts = 0;
        @(posedge clock);
        req <= '{valid: 1'b1, stream: strm, code: code};
        @(posedge clock);
        req.valid <= 1'b0;
        // Slot-start pulse stands only in the cycle right after the take edge
        for (n = 0; n < 40; n++) begin
            #1;
            if (analog_start === 1'b1) starts++;
            if (resp.valid === 1'b1) break;
            @(posedge clock);
        end
        if (n == 40) begin
            fails++;
            end_of_test();
        end else begin
            check(32'(starts), 32'h0000_0001);
            check(32'(resp.is_special), 32'(code > 8'h0F));
            check(32'(resp.error), 32'(err));
            check(32'(clr), 32'(exp_clr));
            if (!err) check(strm ? 32'(resp.data[15:0]) : resp.data, exp);
        end
    endtask

    task automatic t_ports;
        pins <= '{flexible_io_port: 8'h12, extended_io_port: 8'h34,
                  control_io_port: 8'h56, multiplexer_io_port: 8'h78};
        repeat (3) @(posedge clock);
        entry(1'b1, 8'hC1, 32'h0000_3412, 1'b0, 6'h00);
        entry(1'b1, 8'hC2, 32'h0000_7856, 1'b0, 6'h00);
        entry(1'b1, 8'h03, 32'h0000_3C3C, 1'b0, 6'h00);
        $display("Test ports done");
    endtask

    task automatic t_capture;
        slot_len <= 4'h6;
        entry(1'b1, 8'hC8, 32'h0000_1111, 1'b0, 6'h00);
        entry(1'b1, 8'hE0, 32'h0000_AAAA, 1'b0, 6'h00);
        entry(1'b1, 8'hC9, 32'h0000_2222, 1'b0, 6'h00);
        entry(1'b1, 8'hE0, 32'h0000_BBBB, 1'b0, 6'h00);
        entry(1'b1, 8'hC8, 32'h0000_1111, 1'b0, 6'h00);
        entry(1'b1, 8'hD3, 32'h0000_4444, 1'b0, 6'h00);
        entry(1'b1, 8'h03, 32'h0000_3C3C, 1'b0, 6'h00);
        entry(1'b1, 8'hC1, 32'h0000_3412, 1'b0, 6'h00);
        entry(1'b1, 8'hE0, 32'h0000_DDDD, 1'b0, 6'h00);
        slot_len <= 4'h0;
        $display("Test capture done");
    endtask

    task automatic t_reset_codes;
        logic [7:0] code;
        for (int k = 0; k < 6; k++) begin
            code = (k < 4) ? 8'hE6 + 8'(k) : 8'hEC + 8'(k);
            entry(1'b1, code, 32'(src[32*k +: 16]), 1'b0, 6'(1 << k));
            entry(1'b1, 8'hE0, 32'(src[32*k+16 +: 16]), 1'b0, 6'h00);
        end
        $display("Test reset codes done");
    endtask

    task automatic t_command;
        entry(1'b1, 8'hCA, 32'h0000_3333, 1'b0, 6'h00);
        entry(1'b0, 8'hD2, 32'hEEEE_5555, 1'b0, 6'h00);
        entry(1'b0, 8'hE9, 32'hFFFF_6666, 1'b0, 6'h08);
        entry(1'b1, 8'hE0, 32'h0000_CCCC, 1'b0, 6'h00);
        entry(1'b0, 8'hE0, 32'h0000_0000, 1'b1, 6'h00);
        entry(1'b1, 8'hFA, 32'h0000_0000, 1'b1, 6'h00);
        $display("Test command done");
    endtask

    initial begin
        fails = 0;
        check_count = 0;
        reset_n = 1'b0;
        slot_len = 4'h0;
        req = '0;
        pins = '0;
        // Timers and counters set up before streaming; plain counts, no period modes
        src = {32'hDDDD_4444, 32'hEEEE_5555, 32'hFFFF_6666, 32'hCCCC_3333,
               32'hBBBB_2222, 32'hAAAA_1111};
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        t_ports();
        t_capture();
        t_reset_codes();
        t_command();
        end_of_test();
    end
endmodule
`default_nettype wire
